// >>> core/rtc_consts.vh
// Constants for the relay threshold controller.
`ifndef RTC_CONSTS_VH
`define RTC_CONSTS_VH
`define RTC_CLK_HZ 50000000
`define RTC_TICK_MS 100
`define RTC_TICK_CYC ((`RTC_CLK_HZ / 1000) * `RTC_TICK_MS)
`define RTC_TENTH_MIN_TICKS 16'h003C
`define RTC_MODE_DISABLED 3'h0
`define RTC_MODE_ON 3'h1
`define RTC_MODE_OFF 3'h2
`define RTC_MODE_IN 3'h3
`define RTC_MODE_OUT 3'h4
`define RTC_MODE_BUS 3'h5
`define RTC_AL_HOLD 2'h0
`define RTC_AL_ON 2'h1
`define RTC_AL_OFF 2'h2
`define RTC_THR_MIN (-999)
`define RTC_THR_MAX 9999
`define RTC_HYS_MAX 999
`define RTC_DLY_MAX 999
`endif

// >>> core/rtc_relay_threshold_controller.v
// Four-channel relay, indicator and buzzer controller driven by thresholds.
`timescale 1ns/1ps
`include "rtc_consts.vh"

// What this block does
// - Disabled mode keeps the relay off unless force-on alarm applies.
// - Direct mode: on above threshold plus hysteresis, off below minus.
// - Inverted mode: off above threshold plus hysteresis, on below minus.
// - Inside window: on between lower plus and upper minus hysteresis.
// - Outside window: on above upper plus or below lower minus hysteresis.
// - Window bounds use the larger and smaller threshold whichever slot.
// - Bus mode relay follows the remote command unless an alarm reaction applies.
// - Thresholds -999..9999, hysteresis 0..999, band twice hysteresis.
// - Second threshold is used only in window modes.
// - Turn on only after condition held for full turn-on delay.
// - Turn off only after condition held for full turn-off delay.
// - Shorter crossings leave relay unchanged and restart qualification.
// - Critical situation applies hold, force-on or force-off reaction.
// - Threshold modes: measurement out of range is critical.
// - Bus mode: bus silence beyond timeout is critical.
// - Force-on energises the relay even when disabled.
// - Indicator LED mirrors the relay in every mode.
// - Bus-commanded states are not restored after power loss.
// - Channels without relay still run logic, driving only the LED.
// - Buzzer sounds on critical if enabled, and on enabled relay activation.
// - Compared value is present value or held peak, per configuration.
module rtc_relay_threshold_controller #(
   parameter NCH = 4,
   parameter [NCH-1:0] RELAY_FITTED = {NCH{1'b1}},
   parameter TICK_CYC = `RTC_TICK_CYC
) (
   // Clock and reset.
   input wire ref_clk,
   input wire rstn,
   // Measurement chain.
   input wire [15:0] presentValue,
   input wire [15:0] peakValue,
   input wire measOutOfRange,
   // Remote bus.
   input wire busDataStrobe,
   input wire [NCH-1:0] busRelayCmd,
   input wire [15:0] busSilenceTimeout,
   // Per-channel configuration, channel i in slice i.
   input wire [NCH*3-1:0] relayMode,
   input wire [NCH*16-1:0] firstThreshold,
   input wire [NCH*16-1:0] secondThreshold,
   input wire [NCH*10-1:0] hysteresisHalfWidth,
   input wire [NCH*10-1:0] turnOnDelay,
   input wire [NCH*10-1:0] turnOffDelay,
   input wire [NCH-1:0] unitMinutes,
   input wire [NCH*2-1:0] alarmReaction,
   input wire [NCH-1:0] usePeak,
   // Buzzer configuration and panel.
   input wire alarmBeepEnable,
   input wire [NCH-1:0] relayBeepEnable,
   input wire silenceRequest,
   // Outputs.
   output reg [NCH-1:0] relayDrive,
   output reg [NCH-1:0] ledDrive,
   output reg buzzer,
   output reg busCritical
);

////////////////////////////////////////////////////////////////////////////////
// Helper functions.

   function signed [17:0] sx;
      input [15:0] v;
      begin
         sx = {{2{v[15]}}, v};
      end
   endfunction

   // Clamp hysteresis into its legal span.
   function signed [17:0] hys;
      input [9:0] h;
      begin
         if (h > `RTC_HYS_MAX)
            hys = 18'sd999;
         else
            hys = {8'h00, h};
      end
   endfunction

   // Clamp a threshold into its legal span.
   function signed [17:0] thr;
      input [15:0] t;
      begin
         if (sx(t) < `RTC_THR_MIN)
            thr = -18'sd999;
         else if (sx(t) > `RTC_THR_MAX)
            thr = 18'sd9999;
         else
            thr = sx(t);
      end
   endfunction

   // Delay setting in tenths of the chosen unit, returned in 0.1 s ticks.
   // A tenth of a minute is 60 ticks, so 99.9 minutes still fits 16 bits.
   function [15:0] dly;
      input [9:0] d;
      input m;
      reg [9:0] c;
      begin
         c = (d > `RTC_DLY_MAX) ? 10'd999 : d;
         if (m)
            dly = c * `RTC_TENTH_MIN_TICKS;
         else
            dly = {6'h00, c};
      end
   endfunction

////////////////////////////////////////////////////////////////////////////////
// Tick generators: 0.1 s tick and 1 s tick for bus silence.

   reg [31:0] tickCnt;
   reg tick;
   reg [3:0] secCnt;
   reg secTick;

   always @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         tickCnt <= 32'h0;
         tick <= 1'b0;
         secCnt <= 4'h0;
         secTick <= 1'b0;
      end else begin
         secTick <= 1'b0;
         if (tickCnt == TICK_CYC - 1) begin
            tickCnt <= 32'h0;
            tick <= 1'b1;
            if (secCnt == 4'h9) begin
               secCnt <= 4'h0;
               secTick <= 1'b1;
            end else begin
               secCnt <= secCnt + 4'h1;
            end
         end else begin
            tickCnt <= tickCnt + 32'h1;
            tick <= 1'b0;
         end
      end
   end

////////////////////////////////////////////////////////////////////////////////
// Bus silence watchdog, counted in seconds. Reset starts with no command
// history, so a bus-driven relay is off until the master speaks again.

   reg [15:0] silenceSec;

   always @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         silenceSec <= 16'h0;
         busCritical <= 1'b0;
      end else if (busDataStrobe) begin
         silenceSec <= 16'h0;
         busCritical <= 1'b0;
      end else begin
         if (secTick && silenceSec != 16'hFFFF)
            silenceSec <= silenceSec + 16'h1;
         busCritical <= (busSilenceTimeout != 16'h0) && (silenceSec > busSilenceTimeout);
      end
   end

   reg [NCH-1:0] busLatch;

   always @(posedge ref_clk or negedge rstn) begin
      if (!rstn)
         busLatch <= {NCH{1'b0}};
      else if (busDataStrobe)
         busLatch <= busRelayCmd;
   end

////////////////////////////////////////////////////////////////////////////////
// Channels. Each slice is independent and has its own qualification counter.

   reg [NCH-1:0] state;
   reg [NCH*16-1:0] qualCnt;
   reg [NCH-1:0] critical;
   reg [NCH-1:0] next_state;
   reg [NCH*16-1:0] next_qualCnt;
   reg [NCH-1:0] next_relay;
   reg [NCH-1:0] activation;

   integer i;
   reg signed [17:0] val, t1, t2, hi, lo, h;
   reg [2:0] md;
   reg wantOn, wantOff, target;
   reg [15:0] need, cnt;

   always @* begin
      next_state = state;
      next_qualCnt = qualCnt;
      next_relay = {NCH{1'b0}};
      critical = {NCH{1'b0}};
      activation = {NCH{1'b0}};
      val = 18'sd0;
      t1 = 18'sd0;
      t2 = 18'sd0;
      hi = 18'sd0;
      lo = 18'sd0;
      h = 18'sd0;
      md = 3'h0;
      wantOn = 1'b0;
      wantOff = 1'b0;
      target = 1'b0;
      need = 16'h0;
      cnt = 16'h0;
      for (i = 0; i < NCH; i = i + 1) begin
         md = relayMode[i*3 +: 3];
         val = usePeak[i] ? sx(peakValue) : sx(presentValue);
         t1 = thr(firstThreshold[i*16 +: 16]);
         t2 = (md == `RTC_MODE_IN || md == `RTC_MODE_OUT) ? thr(secondThreshold[i*16 +: 16]) : t1;
         hi = (t1 > t2) ? t1 : t2;
         lo = (t1 > t2) ? t2 : t1;
         h = hys(hysteresisHalfWidth[i*10 +: 10]);
         wantOn = 1'b0;
         wantOff = 1'b0;
         case (md)
            `RTC_MODE_ON: begin
               wantOn = val > t1 + h;
               wantOff = val < t1 - h;
            end
            `RTC_MODE_OFF: begin
               wantOff = val > t1 + h;
               wantOn = val < t1 - h;
            end
            `RTC_MODE_IN: begin
               wantOn = (val > lo + h) && (val < hi - h);
               wantOff = (val > hi + h) || (val < lo - h);
            end
            `RTC_MODE_OUT: begin
               wantOn = (val > hi + h) || (val < lo - h);
               wantOff = (val > lo + h) && (val < hi - h);
            end
            default: begin
               wantOff = 1'b1;
            end
         endcase
         if (md == `RTC_MODE_BUS)
            critical[i] = busCritical;
         else if (md != `RTC_MODE_DISABLED)
            critical[i] = measOutOfRange;
         else
            critical[i] = 1'b0;
         cnt = qualCnt[i*16 +: 16];
         if (md == `RTC_MODE_BUS) begin
            next_state[i] = busLatch[i];
            next_qualCnt[i*16 +: 16] = 16'h0;
         end else if (md == `RTC_MODE_DISABLED) begin
            next_state[i] = 1'b0;
            next_qualCnt[i*16 +: 16] = 16'h0;
         end else if ((wantOn && !state[i]) || (wantOff && state[i])) begin
            target = !state[i];
            need = state[i] ? dly(turnOffDelay[i*10 +: 10], unitMinutes[i])
                            : dly(turnOnDelay[i*10 +: 10], unitMinutes[i]);
            if (cnt >= need) begin
               next_state[i] = target;
               next_qualCnt[i*16 +: 16] = 16'h0;
            end else if (tick) begin
               next_qualCnt[i*16 +: 16] = cnt + 16'h1;
            end
         end else begin
            next_qualCnt[i*16 +: 16] = 16'h0;
         end
         // Alarm reaction overrides the output only; hold freezes the relay.
         if (critical[i] || (md == `RTC_MODE_DISABLED && measOutOfRange)) begin
            case (alarmReaction[i*2 +: 2])
               `RTC_AL_ON: next_relay[i] = 1'b1;
               `RTC_AL_OFF: next_relay[i] = 1'b0;
               default: next_relay[i] = relayDrive[i] | ledDrive[i];
            endcase
            if (alarmReaction[i*2 +: 2] == `RTC_AL_HOLD || md == `RTC_MODE_DISABLED)
               next_relay[i] = (alarmReaction[i*2 +: 2] == `RTC_AL_ON) ? 1'b1 :
                               (md == `RTC_MODE_DISABLED ? 1'b0 : ledDrive[i]);
         end else begin
            next_relay[i] = next_state[i];
         end
         activation[i] = next_relay[i] && !ledDrive[i];
      end
   end

   always @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         state <= {NCH{1'b0}};
         qualCnt <= {NCH*16{1'b0}};
         relayDrive <= {NCH{1'b0}};
         ledDrive <= {NCH{1'b0}};
      end else begin
         state <= next_state;
         qualCnt <= next_qualCnt;
         relayDrive <= next_relay & RELAY_FITTED;
         ledDrive <= next_relay;
      end
   end

////////////////////////////////////////////////////////////////////////////////
// Buzzer: latched on events, a button press silences it. A new event in the
// same cycle as a press still sounds, so no alarm onset is lost.

   reg critPrev;
   wire anyCrit = |critical;

   always @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         buzzer <= 1'b0;
         critPrev <= 1'b0;
      end else begin
         critPrev <= anyCrit;
         if ((alarmBeepEnable && anyCrit && !critPrev) || |(activation & relayBeepEnable))
            buzzer <= 1'b1;
         else if (silenceRequest)
            buzzer <= 1'b0;
      end
   end

endmodule // rtc_relay_threshold_controller

// >>> verification/rtc_far_side.sv
// Measurement chain, remote bus master and front panel model.
`timescale 1ns/1ps
module rtc_far_side (
   // Clock.
   input wire ref_clk,
   // Measurement, bus and panel side.
   output reg [15:0] presentValue,
   output reg [15:0] peakValue,
   output reg measOutOfRange,
   output reg busDataStrobe,
   output reg [3:0] busRelayCmd,
   output reg silenceRequest
);
   initial begin
      {presentValue, peakValue, measOutOfRange, busDataStrobe, busRelayCmd, silenceRequest} = 0;
   end
   task meas(input [15:0] p, input [15:0] k, input o);
      @(negedge ref_clk);
      {presentValue, peakValue, measOutOfRange} = {p, k, o};
   endtask
   // The command is scrambled once the strobe drops so a late sample shows up.
   task bus(input [3:0] c);
      @(negedge ref_clk);
      {busRelayCmd, busDataStrobe} = {c, 1'b1};
      @(negedge ref_clk);
      {busRelayCmd, busDataStrobe} = {~c, 1'b0};
   endtask
   task press;
      @(negedge ref_clk);
      silenceRequest = 1'b1;
      @(negedge ref_clk);
      silenceRequest = 1'b0;
   endtask
endmodule // rtc_far_side

// >>> verification/rtc_relay_threshold_controller_properties.sv
// Port-level checker for the relay threshold controller.
`timescale 1ns/1ps
module rtc_checker #(
   parameter NCH = 4,
   parameter TICK_CYC = 10
) (
   // Clock, reset and inputs.
   input wire ref_clk,
   input wire rstn,
   input wire [15:0] presentValue,
   input wire measOutOfRange,
   input wire busDataStrobe,
   input wire [NCH-1:0] busRelayCmd,
   input wire [NCH*3-1:0] relayMode,
   input wire [NCH*16-1:0] firstThreshold,
   input wire [NCH*10-1:0] hysteresisHalfWidth,
   input wire [NCH*10-1:0] turnOnDelay,
   input wire [NCH*10-1:0] turnOffDelay,
   input wire [NCH*2-1:0] alarmReaction,
   input wire [NCH-1:0] usePeak,
   input wire [NCH-1:0] relayBeepEnable,
   // Outputs.
   input wire [NCH-1:0] relayDrive,
   input wire [NCH-1:0] ledDrive,
   input wire buzzer,
   input wire busCritical
);
   wire signed [17:0] hys = {8'h00, hysteresisHalfWidth[9:0]};
   wire signed [17:0] upper = $signed(firstThreshold[15:0]) + hys;
   wire signed [17:0] lower = $signed(firstThreshold[15:0]) - hys;
   wire signed [15:0] value = presentValue;
   wire direct = relayMode[2:0] == 3'h1 && !measOutOfRange && !usePeak[0];
   default clocking @(posedge ref_clk); endclocking
   default disable iff (!rstn);
   chk_led_mirror: assert property (ledDrive == relayDrive)
      else $error("led differs from relay");
   chk_reset_clear: assert property (!$past(rstn) |-> relayDrive == 4'h0 && !buzzer)
      else $error("output set after reset");
   chk_direct_on: assert property ((direct && turnOnDelay[9:0] == 10'h000 && value > upper) [*2]
      |=> relayDrive[0]) else $error("direct relay not on");
   chk_direct_off: assert property ((direct && turnOffDelay[9:0] == 10'h000 && value < lower) [*2]
      |=> !relayDrive[0]) else $error("direct relay not off");
   chk_disabled_off: assert property ((relayMode[2:0] == 3'h0 && alarmReaction[1:0] != 2'h1) [*2]
      |=> !relayDrive[0]) else $error("disabled relay on");
   chk_force_on: assert property ((measOutOfRange && alarmReaction[1:0] == 2'h1 && relayMode[2:0] < 3'h5) [*2]
      |=> relayDrive[0]) else $error("force on ignored");
   chk_bus_follow: assert property (busDataStrobe && relayMode[5:3] == 3'h5 && !busCritical
      ##1 relayMode[5:3] == 3'h5 |=> relayDrive[1] == $past(busRelayCmd[1], 2)) else $error("bus cmd lost");
   chk_buzzer_menu_relay: assert property (relayBeepEnable[0] && $rose(relayDrive[0]) |-> buzzer)
      else $error("no buzzer_menu on relay");
   cover property (relayDrive[0] && buzzer);
   cover property ($rose(busCritical));
   cover property (measOutOfRange && relayDrive[0]);
endmodule // rtc_checker
bind rtc_relay_threshold_controller rtc_checker #(.NCH(NCH), .TICK_CYC(TICK_CYC)) chk (.ref_clk(ref_clk),
   .rstn(rstn), .presentValue(presentValue), .measOutOfRange(measOutOfRange), .busDataStrobe(busDataStrobe),
   .busRelayCmd(busRelayCmd), .relayMode(relayMode), .firstThreshold(firstThreshold),
   .hysteresisHalfWidth(hysteresisHalfWidth), .turnOnDelay(turnOnDelay), .turnOffDelay(turnOffDelay),
   .alarmReaction(alarmReaction), .usePeak(usePeak), .relayBeepEnable(relayBeepEnable),
   .relayDrive(relayDrive), .ledDrive(ledDrive), .buzzer(buzzer), .busCritical(busCritical));

// >>> verification/rtc_relay_threshold_controller_tb_top.sv
// Self-checking bench for the relay threshold controller.
`timescale 1ns/1ps
module rtc_relay_threshold_controller_tb_top;
   reg ref_clk = 1'b0;
   reg rstn = 1'b0;
   reg [11:0] mode = 12'h000;
   reg [63:0] t1 = 64'h0, t2 = 64'h0;
   reg [39:0] hy = 40'h0, don = 40'h0, doff = 40'h0;
   reg [7:0] al = 8'h00;
   reg [3:0] pk = 4'h0, rbe = 4'h0;
   reg abe = 1'b0;
   reg [3:0] um = 4'h0;
   reg [15:0] bto = 16'h0001;
   wire [15:0] pv, kv;
   wire oor, bs, sr, bz, bcr;
   wire [3:0] bc, rel, led;
   wire [4:0] obs = {bcr, rel};
   integer badCount = 0, checked = 0, seed = 32'h9d1c, i, m, a, b, h, v, t, u, p = 0;
   always #10 ref_clk = ~ref_clk;
   rtc_far_side far (.ref_clk(ref_clk), .presentValue(pv), .peakValue(kv), .measOutOfRange(oor),
      .busDataStrobe(bs), .busRelayCmd(bc), .silenceRequest(sr));
   rtc_relay_threshold_controller #(.TICK_CYC(10)) DUT (.ref_clk(ref_clk), .rstn(rstn), .presentValue(pv),
      .peakValue(kv), .measOutOfRange(oor), .busDataStrobe(bs), .busRelayCmd(bc), .busSilenceTimeout(bto),
      .relayMode(mode), .firstThreshold(t1), .secondThreshold(t2), .hysteresisHalfWidth(hy),
      .turnOnDelay(don), .turnOffDelay(doff), .unitMinutes(um), .alarmReaction(al), .usePeak(pk),
      .alarmBeepEnable(abe), .relayBeepEnable(rbe), .silenceRequest(sr), .relayDrive(rel),
      .ledDrive(led), .buzzer(bz), .busCritical(bcr));
   ////////////////////////////////////////////////////////////////////////////
   function integer mdl(input integer m, v, a, b, h, p);
      integer lo, hi;
      begin
         lo = a < b ? a : b;
         hi = a < b ? b : a;
         case (m)
            1: mdl = v > a + h ? 1 : v < a - h ? 0 : p;
            2: mdl = v > a + h ? 0 : v < a - h ? 1 : p;
            3: mdl = (v > lo + h && v < hi - h) ? 1 : (v < lo - h || v > hi + h) ? 0 : p;
            4: mdl = (v > hi + h || v < lo - h) ? 1 : (v > lo + h && v < hi - h) ? 0 : p;
            default: mdl = 0;
         endcase
      end
   endfunction
   task chk(input logic [15:0] g, input logic [15:0] e, input string n);
      checked = checked + 1;
      if (g !== e) begin
         badCount = badCount + 1;
         $display("Error %s expected %0h seen %0h", n, e, g);
      end
   endtask
   task cyc(input integer n);
      repeat (n) @(negedge ref_clk);
   endtask
   task close_out;
      $display("checked %0d mismatches %0d", checked, badCount);
      if (badCount == 0 && checked > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask
   // A wait that runs out is a mismatch and ends the run at once.
   task wrel(input integer c, input logic l, input integer lim);
      for (t = 0; t < lim && obs[c] !== l; t = t + 1)
         cyc(1);
      chk(obs[c], l, "wait level");
      if (obs[c] !== l)
         close_out;
   endtask
   ////////////////////////////////////////////////////////////////////////////
   initial begin
      cyc(4);
      rstn = 1'b1;
      for (i = 0; i < 60; i = i + 1) begin
         m = 1 + {$random(seed)} % 4;
         a = -999 + {$random(seed)} % 9000;
         b = a + 300 + {$random(seed)} % 700;
         if ($random(seed) & 1)
            {a, b} = {b, a};
         h = {$random(seed)} % 100;
         v = (a < b ? a : b) - 400 + {$random(seed)} % 1700;
         u = $random(seed) & 1;
         p = mdl(m, v, a, b, h, p);
         // Value and settings change in one step, so the old value never meets the new thresholds.
         far.meas(u ? ~v[15:0] : v[15:0], u ? v[15:0] : ~v[15:0], 1'b0);
         {mode[2:0], t1[15:0], t2[15:0], hy[9:0], pk[0]} = {m[2:0], a[15:0], b[15:0], h[9:0], u[0]};
         cyc(3);
         chk(rel[0], p[15:0], "relay");
         chk(led[0], p[15:0], "led");
      end
      $display("threshold modes done");
      {mode[2:0], t1[15:0], hy[9:0], pk[0]} = {3'h1, 16'h0000, 10'h00A, 1'b0};
      far.meas(16'hFF9C, 16'h0, 1'b0);
      cyc(3);
      don[9:0] = 10'h003;
      far.meas(16'h0064, 16'h0, 1'b0);
      cyc(15);
      chk(rel[0], 0, "early on");
      far.meas(16'h0000, 16'h0, 1'b0);
      cyc(2);
      far.meas(16'h0064, 16'h0, 1'b0);
      cyc(20);
      chk(rel[0], 0, "requalify");
      wrel(0, 1'b1, 45);
      doff[9:0] = 10'h002;
      far.meas(16'hFF9C, 16'h0, 1'b0);
      cyc(8);
      chk(rel[0], 1, "early off");
      wrel(0, 1'b0, 35);
      {don, doff} = 80'h0;
      {um[0], don[9:0]} = {1'b1, 10'h001};
      far.meas(16'h0064, 16'h0, 1'b0);
      cyc(500);
      chk(rel[0], 0, "minute early");
      wrel(0, 1'b1, 200);
      {um[0], don[9:0]} = {1'b0, 10'h000};
      $display("delays done");
      abe = 1'b1;
      for (i = 0; i < 3; i = i + 1) begin
         {mode[2:0], al[1:0]} = {3'h1, 2'h0};
         far.meas(16'h0064, 16'h0, 1'b0);
         cyc(3);
         al[1:0] = i[1:0];
         far.meas(16'hFF9C, 16'h0, 1'b1);
         cyc(3);
         chk(rel[0], i != 2, "alarm reaction");
         chk(bz, 1, "alarm buzzer_menu");
         far.press;
         cyc(1);
         chk(bz, 0, "silence");
      end
      {mode[2:0], al[1:0]} = {3'h0, 2'h1};
      cyc(3);
      chk(rel[0], 1, "forced disabled");
      al[1:0] = 2'h2;
      cyc(3);
      chk(rel[0], 0, "disabled");
      far.meas(16'h0000, 16'h0, 1'b0);
      {mode[2:0], rbe[0]} = {3'h1, 1'b1};
      far.press;
      far.meas(16'h0064, 16'h0, 1'b0);
      cyc(2);
      chk(bz, 1, "relay buzzer_menu");
      $display("alarms done");
      mode[5:3] = 3'h5;
      far.bus(4'h2);
      cyc(3);
      chk(rel[1], 1, "bus on");
      far.bus(4'h0);
      cyc(3);
      chk(rel[1], 0, "bus off");
      chk(bcr, 0, "bus quiet");
      al[3:2] = 2'h1;
      wrel(4, 1'b1, 300);
      cyc(2);
      chk(rel[1], 1, "bus alarm");
      al[3:2] = 2'h0;
      far.bus(4'h2);
      cyc(3);
      rstn = 1'b0;
      cyc(2);
      chk(rel, 0, "in reset");
      rstn = 1'b1;
      cyc(3);
      chk(rel[1], 0, "not restored");
      $display("bus done");
      close_out;
   end
endmodule // rtc_relay_threshold_controller_tb_top
